// >>> rtl/pms_mii_core.v
// mii carrier, collision, transmit clock, transmit path and management
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.vh"
module pms_mii_core #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW    = 3,
   parameter HB_CYC     = `PMS_HB_CYC
) (
   // clocking
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        ce,
   // register port
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // management pins
   input  wire        mdc,
   input  wire        mdio_in,
   output reg         mdio_out,
   output reg         mdio_oe,
   // line activity
   input  wire        rx_active,
   input  wire        signal_detect,
   output reg         crs,
   output reg         col,
   // transmit clock
   input  wire        clock_generator_pll,
   output wire        tx_clk,
   // transmit from mac
   input  wire        tx_en,
   input  wire        tx_er,
   input  wire [3:0]  txd,
   output wire        tx_fifo_ready,
   // transmit toward medium
   output reg         tx_sym_valid,
   output reg  [3:0]  tx_sym_data,
   output reg         tx_sym_halt,
   input  wire        media_ready
);
   localparam S_PRE  = 3'd0;
   localparam S_ST   = 3'd1;
   localparam S_HDR  = 3'd2;
   localparam S_TARD = 3'd3;
   localparam S_RD   = 3'd4;
   localparam S_WR   = 3'd5;
   localparam S_SKIP = 3'd6;

   // half periods in pll ticks, cut to the divider width on purpose
   localparam [31:0] HALF_100 = `PMS_HALF(`PMS_TXC_100_HZ);
   localparam [31:0] HALF_SER = `PMS_HALF(`PMS_TXC_SER_HZ);
   localparam [31:0] HALF_NIB = `PMS_HALF(`PMS_TXC_NIB_HZ);

   // mode registers
   reg  [4:0]  ctrl;
   reg         hb_en;
   reg  [4:0]  phyad;
   wire        fdx    = ctrl[`PMS_B_FDX];
   wire        spd100 = ctrl[`PMS_B_SPD100];
   wire        rpt    = ctrl[`PMS_B_RPT];
   wire        sym    = ctrl[`PMS_B_SYM];
   wire        ser10  = ctrl[`PMS_B_SER];

   // transmit path
   wire        fifo_valid;
   wire [4:0]  fifo_data;
   wire        fifo_pop = ~tx_sym_valid | media_ready;
   wire [4:0]  tx_word;
   reg         tx_act_q;
   reg  [3:0]  hb_cnt;
   reg         hb_pulse;
   reg         next_crs;
   reg         next_col;
   wire        tx_act = tx_en | fifo_valid | tx_sym_valid;
   wire        hb_arm = ~spd100 & ~fdx & ~rpt & hb_en;

   // management shifter
   reg         mdc_s1;
   reg         mdc_s2;
   reg         mdc_s3;
   reg         mdi_s1;
   reg         mdi_s2;
   wire        mdc_rise = mdc_s2 & ~mdc_s3;
   reg  [2:0]  mstate;
   reg  [5:0]  mcnt;
   reg  [11:0] hdr;
   reg  [15:0] mshift;
   wire [11:0] hdr_n = {hdr[10:0], mdi_s2};
   wire [4:0]  hdr_ra = hdr_n[4:0];
   reg  [15:0] mreg_val;
   reg         mwr_go;
   reg  [4:0]  mwr_ra;
   reg  [15:0] mwr_data;
   reg  [5:0]  tx_half;
   reg  [31:0] next_rdata;

   // 100M error during enable replaces the nibble with halt
   assign tx_word = (spd100 & tx_er) ? {1'b1, `PMS_HALT} : {1'b0, txd}; // see RULE15

   pms_fifo #(
      .WIDTH (5),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .ce        (ce),
      .in_valid  (tx_en),
      .in_data   (tx_word),
      .in_ready  (tx_fifo_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (fifo_pop)
   );

   // only tx_en qualifies a nibble into the buffer
   always @(posedge clk_sys) begin
      if (reset) begin
         tx_sym_valid <= 1'b0;
         tx_sym_data  <= 4'h0;
         tx_sym_halt  <= 1'b0;
      end else if (ce && fifo_pop) begin // see RULE14
         tx_sym_valid <= fifo_valid;
         tx_sym_data  <= fifo_data[3:0];
         tx_sym_halt  <= fifo_data[4];
      end
   end

   // transmit clock rate follows speed and serial selection
   always @* begin
      if (spd100)
         tx_half = HALF_100[5:0]; // see RULE11
      else if (ser10)
         tx_half = HALF_SER[5:0]; // see RULE13
      else
         tx_half = HALF_NIB[5:0]; // see RULE12
   end

   pms_clkdiv #(
      .CW (6)
   ) u_txclk (
      .clk_sys (clk_sys),
      .reset   (reset),
      .ce      (ce),
      .tick    (clock_generator_pll),
      .half    (tx_half),
      .clk_out (tx_clk)
   );

   // heartbeat after each transmission end in 10M half duplex with hb_en set, not in repeater mode
   always @(posedge clk_sys) begin
      if (reset) begin
         tx_act_q <= 1'b0;
         hb_cnt   <= 4'h0;
         hb_pulse <= 1'b0;
      end else if (ce) begin
         tx_act_q <= tx_act;
         if (tx_act_q & ~tx_act & hb_arm) begin // see RULE8 RULE9 RULE10
            hb_cnt   <= HB_CYC[3:0];
            hb_pulse <= 1'b1;
         end else if (hb_cnt != 4'h0) begin
            hb_cnt   <= hb_cnt - 4'h1;
            hb_pulse <= (hb_cnt != 4'h1);
         end else begin
            hb_pulse <= 1'b0;
         end
      end
   end

   // status pins derive only from internal activity
   always @* begin
      if (sym)
         next_crs = signal_detect; // see RULE6
      else if (fdx | rpt)
         next_crs = rx_active; // see RULE5
      else
         next_crs = rx_active | tx_act; // see RULE4
      if (fdx)
         next_col = 1'b0; // see RULE10
      else
         next_col = (rx_active & tx_act) | (hb_pulse & ~rpt); // see RULE7
   end

   always @(posedge clk_sys) begin
      if (reset) begin
         crs <= 1'b0;
         col <= 1'b0;
      end else if (ce) begin // see RULE17
         crs <= next_crs;
         col <= next_col;
      end
   end

   // management clock sampled, not used as a clock
   always @(posedge clk_sys) begin
      if (reset) begin
         mdc_s1 <= 1'b0;
         mdc_s2 <= 1'b0;
         mdc_s3 <= 1'b0;
         mdi_s1 <= 1'b1;
         mdi_s2 <= 1'b1;
      end else if (ce) begin // see RULE2
         mdc_s1 <= mdc;
         mdc_s2 <= mdc_s1;
         mdc_s3 <= mdc_s2;
         mdi_s1 <= mdio_in;
         mdi_s2 <= mdi_s1;
      end
   end

   // 2.5 MHz ceiling leaves four samples per management period
   always @* begin
      case (hdr_ra)
         `PMS_MR_CTRL:  mreg_val = {11'h000, ctrl}; // see RULE1
         `PMS_MR_STAT:  mreg_val = {12'h000, tx_act, rx_active, col, crs};
         `PMS_MR_PHYAD: mreg_val = {11'h000, phyad};
         `PMS_MR_HBCTL: mreg_val = {8'h00, hb_en, 7'h00};
         default:       mreg_val = 16'h0000;
      endcase
   end

   // clause 22 frame: preamble, start, op, phy, reg, turnaround, data
   always @(posedge clk_sys) begin
      if (reset) begin
         mstate   <= S_PRE;
         mcnt     <= 6'd0;
         hdr      <= 12'h000;
         mshift   <= 16'h0000;
         mdio_out <= 1'b0;
         mdio_oe  <= 1'b0;
         mwr_go   <= 1'b0;
         mwr_ra   <= 5'h00;
         mwr_data <= 16'h0000;
      end else if (ce) begin
         mwr_go <= 1'b0;
         if (mdc_rise) begin
            case (mstate)
               S_PRE: begin // see RULE16
                  if (mdi_s2) begin
                     if (mcnt != `PMS_PRE_LEN)
                        mcnt <= mcnt + 6'd1;
                  end else if (mcnt == `PMS_PRE_LEN) begin
                     mstate <= S_ST;
                  end else begin
                     mcnt <= 6'd0;
                  end
               end
               S_ST: begin
                  mcnt   <= 6'd0;
                  mstate <= mdi_s2 ? S_HDR : S_PRE;
               end
               S_HDR: begin
                  hdr  <= hdr_n;
                  mcnt <= mcnt + 6'd1;
                  if (mcnt == `PMS_HDR_LEN - 1) begin
                     mcnt <= 6'd0;
                     if (hdr_n[9:5] != phyad)
                        mstate <= S_SKIP;
                     else if (hdr_n[11:10] == `PMS_OP_RD) begin
                        mshift <= mreg_val;
                        mstate <= S_TARD;
                     end else if (hdr_n[11:10] == `PMS_OP_WR)
                        mstate <= S_WR;
                     else
                        mstate <= S_SKIP;
                  end
               end
               S_TARD: begin
                  // second turnaround bit is a driven zero
                  mdio_oe  <= 1'b1; // see RULE3
                  mdio_out <= 1'b0;
                  mstate   <= S_RD;
               end
               S_RD: begin
                  mcnt <= mcnt + 6'd1;
                  if (mcnt == `PMS_DAT_LEN) begin
                     mdio_oe  <= 1'b0; // see RULE3
                     mdio_out <= 1'b0;
                     mcnt     <= 6'd0;
                     mstate   <= S_PRE;
                  end else begin
                     mdio_out <= mshift[15];
                     mshift   <= {mshift[14:0], 1'b0};
                  end
               end
               S_WR: begin
                  // two turnaround bits then sixteen data bits
                  mcnt   <= mcnt + 6'd1;
                  mshift <= {mshift[14:0], mdi_s2};
                  if (mcnt == `PMS_DAT_LEN + 1) begin
                     mwr_go   <= 1'b1;
                     mwr_ra   <= hdr[4:0];
                     mwr_data <= {mshift[14:0], mdi_s2};
                     mcnt     <= 6'd0;
                     mstate   <= S_PRE;
                  end
               end
               S_SKIP: begin
                  mcnt <= mcnt + 6'd1;
                  if (mcnt == `PMS_DAT_LEN + 1) begin
                     mcnt   <= 6'd0;
                     mstate <= S_PRE;
                  end
               end
               default: begin
                  mcnt   <= 6'd0;
                  mstate <= S_PRE;
               end
            endcase
         end
      end
   end

   // register writes; the bus wins over a same-cycle management write
   always @(posedge clk_sys) begin
      if (reset) begin
         ctrl  <= `PMS_CTRL_RST;
         hb_en <= `PMS_HBCTL_RST;
         phyad <= `PMS_PHYAD_RST;
      end else if (ce) begin
         if (reg_wr) begin
            case (reg_addr)
               `PMS_OFF_CTRL:  ctrl  <= reg_wdata[4:0];
               `PMS_OFF_PHYAD: phyad <= reg_wdata[4:0];
               `PMS_OFF_HBCTL: hb_en <= reg_wdata[`PMS_B_HBEN];
               default: ;
            endcase
         end else if (mwr_go) begin
            case (mwr_ra)
               `PMS_MR_CTRL:  ctrl  <= mwr_data[4:0];
               `PMS_MR_PHYAD: phyad <= mwr_data[4:0];
               `PMS_MR_HBCTL: hb_en <= mwr_data[`PMS_B_HBEN];
               default: ;
            endcase
         end
      end
   end

   // read data stands for one cycle only; unmapped reads as zero
   always @* begin
      case (reg_addr)
         `PMS_OFF_CTRL:  next_rdata = {27'h0000000, ctrl};
         `PMS_OFF_STAT:  next_rdata = {28'h0000000, tx_act, rx_active,
                                       col, crs};
         `PMS_OFF_PHYAD: next_rdata = {27'h0000000, phyad};
         `PMS_OFF_HBCTL: next_rdata = {24'h000000, hb_en, 7'h00};
         default:        next_rdata = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys) begin
      if (reset)
         reg_rdata <= 32'h00000000;
      else if (ce)
         reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
   end
endmodule
`default_nettype wire

// >>> rtl/pms_consts.vh
// constants for the mii status, clock and management block
//Behaviour
//RULE1 - management clock runs at most 2.5 MHz
//RULE2 - management logic tolerates unrelated management clock
//RULE3 - data line released when not driving
//RULE4 - half duplex: carrier on receive or transmit
//RULE5 - repeater/full duplex: carrier on receive only
//RULE6 - symbol mode: carrier pin shows signal detect
//RULE7 - half duplex: collision on simultaneous activity
//RULE8 - 10M half duplex heartbeat pulse after transmit
//RULE9 - repeater mode suppresses heartbeat
//RULE10 - full duplex: collision always low
//RULE11 - 100M transmit clock 25 MHz from pll
//RULE12 - 10M nibble transmit clock 2.5 MHz
//RULE13 - 10M serial transmit clock 10 MHz
//RULE14 - transmit enable marks valid nibble data
//RULE15 - 100M transmit error substitutes halt code
//RULE16 - management frames follow clause 22 format
//RULE17 - carrier/collision follow internal activity only
`ifndef PMS_CONSTS_VH
`define PMS_CONSTS_VH
`define PMS_OFF_CTRL    8'h00
`define PMS_OFF_STAT    8'h04
`define PMS_OFF_PHYAD   8'h08
`define PMS_OFF_HBCTL   8'h18
`define PMS_MR_CTRL     5'h00
`define PMS_MR_STAT     5'h01
`define PMS_MR_PHYAD    5'h02
`define PMS_MR_HBCTL    5'h18
`define PMS_B_FDX       0
`define PMS_B_SPD100    1
`define PMS_B_RPT       2
`define PMS_B_SYM       3
`define PMS_B_SER       4
`define PMS_B_HBEN      7
`define PMS_CTRL_RST    5'h00
`define PMS_HBCTL_RST   1'b0
`define PMS_PHYAD_RST   5'h01
`define PMS_CLK_NS      100
`define PMS_HB_NS       1000
`define PMS_HB_CYC      (`PMS_HB_NS / `PMS_CLK_NS)
`define PMS_PLL_HZ      100000000
`define PMS_TXC_100_HZ  25000000
`define PMS_TXC_NIB_HZ  2500000
`define PMS_TXC_SER_HZ  10000000
`define PMS_HALF(hz)    (`PMS_PLL_HZ / (2 * (hz)))
`define PMS_PRE_LEN     32
`define PMS_HDR_LEN     12
`define PMS_DAT_LEN     16
`define PMS_OP_RD       2'b10
`define PMS_OP_WR       2'b01
`define PMS_HALT        4'h4
`endif

// >>> rtl/pms_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pms_fifo #(
   parameter WIDTH = 5,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // clocking
   input  wire             clk_sys,
   input  wire             reset,
   input  wire             ce,
   // fill side
   input  wire             in_valid,
   input  wire [WIDTH-1:0] in_data,
   output reg              in_ready,
   // drain side
   output reg              out_valid,
   output wire [WIDTH-1:0] out_data,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push = in_valid & in_ready;
   wire            pop = out_valid & out_ready;
   reg  [AW:0]     next_count;

   assign out_data = mem[rd_ptr];

   always @* begin
      next_count = count;
      if (push & ~pop)
         next_count = count + 1'b1;
      else if (pop & ~push)
         next_count = count - 1'b1;
   end

   always @(posedge clk_sys) begin
      if (reset) begin
         wr_ptr    <= {AW{1'b0}};
         rd_ptr    <= {AW{1'b0}};
         count     <= {(AW+1){1'b0}};
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else if (ce) begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop)
            rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         count     <= next_count;
         in_ready  <= (next_count != DEPTH);
         out_valid <= (next_count != {(AW+1){1'b0}});
      end
   end
endmodule
`default_nettype wire

// >>> rtl/pms_clkdiv.v
// divides the pll tick stream into a square transmit clock
`timescale 1ns/1ps
`default_nettype none
module pms_clkdiv #(
   parameter CW = 6
) (
   // clocking
   input  wire          clk_sys,
   input  wire          reset,
   input  wire          ce,
   // pll tick and half period in ticks
   input  wire          tick,
   input  wire [CW-1:0] half,
   // divided clock
   output reg           clk_out
);
   reg [CW-1:0] cnt;

   always @(posedge clk_sys) begin
      if (reset) begin
         cnt     <= {CW{1'b0}};
         clk_out <= 1'b0;
      end else if (ce && tick) begin
         // a mode change stretches or cuts short the current half period
         if (cnt + 1'b1 >= half) begin
            cnt     <= {CW{1'b0}};
            clk_out <= ~clk_out;
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/pms_unused_placeholder_none.v
// intentionally empty of logic: no extra module
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> bench/pms_mii_asserts.sv
// port checks for the mii status block
`timescale 1ns/1ps
`default_nettype none
module pms_mii_asserts (
   // clocking
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        ce,
   // register writes
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   // watched pins
   input wire logic        mdio_out,
   input wire logic        mdio_oe,
   input wire logic        rx_active,
   input wire logic        signal_detect,
   input wire logic        crs,
   input wire logic        col,
   input wire logic        tx_en,
   input wire logic        tx_sym_valid,
   input wire logic [3:0]  tx_sym_data,
   input wire logic        tx_sym_halt
);
   // shadow mode; only trusted once held two cycles, outputs lag a cycle
   logic [4:0] mode;
   logic [4:0] mode_d;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mode   <= 5'h00;
         mode_d <= 5'h00;
      end else if (ce) begin
         if (reg_wr && reg_addr == 8'h00)
            mode <= reg_wdata[4:0];
         mode_d <= mode;
      end
   end
   wire logic [4:0] on   = mode & mode_d;
   wire logic [4:0] off  = ~(mode | mode_d);
   wire logic       half = off[0] && off[2] && off[3];

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence both_busy;
      rx_active && tx_en;
   endsequence

   rel_reset_a: assert property (
      $past(reset) |-> !mdio_oe && !crs && !col)
      else $error("outputs active after reset");
   fdx_col_a: assert property (
      on[0] |-> !col)
      else $error("collision in full duplex");
   rx_only_a: assert property (
      (on[0] || on[2]) && off[3] |-> crs == $past(rx_active))
      else $error("carrier not from receive alone");
   sym_det_a: assert property (
      on[3] |-> crs == $past(signal_detect))
      else $error("carrier not signal detect");
   half_crs_a: assert property (
      half && $past(rx_active || tx_en) |-> crs)
      else $error("carrier missing in half duplex");
   half_col_a: assert property (
      both_busy ##0 half |=> col)
      else $error("collision missing");
   rpt_beat_a: assert property (
      on[2] && !$past(rx_active) |-> !col)
      else $error("heartbeat in repeater mode");
   halt_code_a: assert property (
      tx_sym_valid && tx_sym_halt |-> tx_sym_data == 4'h4 && mode_d[1])
      else $error("bad halt symbol");
   ta_zero_a: assert property (
      $rose(mdio_oe) |-> !mdio_out)
      else $error("turnaround bit not zero");
endmodule
`default_nettype wire

// >>> bench/pms_sme_model.sv
// station management stand-in: drives mdc and the host side of mdio
`timescale 1ns/1ps
`default_nettype none
module pms_sme_model (
   // clocking
   input  wire logic clk_sys,
   // management pins
   input  wire logic mdio,
   output var  logic mdc,
   output var  logic host_out,
   output var  logic host_oe
);
   initial begin
      mdc      = 1'b0;
      host_out = 1'b1;
      host_oe  = 1'b0;
   end

   // frame plus one idle bit; half >= 2 keeps mdc at or under 2.5 MHz
   task automatic frame(input logic rd, input logic [4:0] pa,
                        input logic [4:0] ra, input logic [15:0] wd,
                        input int half, output logic [15:0] rv);
      logic [63:0] bits;
      bits = {32'hffff_ffff, 2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
      for (int i = 63; i >= -1; i--) begin
         @(posedge clk_sys);
         mdc      <= 1'b0;
         host_oe  <= i >= 0 && !(rd && i < 18);
         host_out <= i >= 0 ? bits[i] : 1'b1;
         repeat (half) @(posedge clk_sys);
         mdc <= 1'b1;
         if (i >= 0 && i < 16)
            rv[i] = mdio;
         repeat (half - 1) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      mdc <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> bench/test_phy_mii_status_and_clocks.sv
// self-checking bench for the mii status, clock and management block
`timescale 1ns/1ps
`default_nettype none
module test_phy_mii_status_and_clocks;
   localparam int HB = 10;
   localparam int DEPTH = 8;
   localparam logic [4:0] MT [4] = '{5'h00, 5'h01, 5'h04, 5'h08};
   localparam logic [1:0] EX [3][4] = '{'{2'b11, 2'b10, 2'b11, 2'b01},
      '{2'b10, 2'b00, 2'b00, 2'b00}, '{2'b10, 2'b10, 2'b10, 2'b10}};
   localparam logic [4:0] HM [4] = '{5'h00, 5'h04, 5'h01, 5'h00};
   localparam int HX [4] = '{HB, 0, 0, 0};
   localparam logic [4:0] CM [3] = '{5'h02, 5'h00, 5'h10};
   localparam int CP [3] = '{4, 40, 10};
   logic        clk_sys, reset, ce, reg_wr, reg_rd, mdc, mdio_out, mdio_oe;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic        host_out, host_oe, rx_active, signal_detect, crs, col;
   logic        clock_generator_pll, tx_clk, tx_en, tx_er, tx_fifo_ready;
   logic        tx_sym_valid, tx_sym_halt, media_ready, rec, spd, prev;
   logic [3:0]  txd, tx_sym_data;
   logic [15:0] rv;
   logic [4:0]  q[$], got[$];
   int          fails, n_compared, cyc, n, seen;
   // pull-up: a released line reads high
   wire logic   mdio = mdio_oe ? mdio_out : host_oe ? host_out : 1'b1;

   pms_mii_core #(.FIFO_DEPTH(DEPTH), .FIFO_AW(3), .HB_CYC(HB))
      pms_mii_core_i (.clk_sys, .reset, .ce, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .mdc, .mdio_in(mdio), .mdio_out, .mdio_oe,
      .rx_active, .signal_detect, .crs, .col, .clock_generator_pll, .tx_clk,
      .tx_en, .tx_er, .txd, .tx_fifo_ready, .tx_sym_valid, .tx_sym_data,
      .tx_sym_halt, .media_ready);
   pms_sme_model pms_sme_model_i (.clk_sys, .mdio, .mdc, .host_out, .host_oe);

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         print_verdict();
      end
      if (rec && tx_en && tx_fifo_ready)
         q.push_back(spd && tx_er ? 5'h14 : {1'b0, txd});
      if (rec && tx_sym_valid && media_ready)
         got.push_back({tx_sym_halt, tx_sym_data});
   end

   task automatic cmp(input string what, input logic [31:0] e,
                      input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      cmp("reg_rdata", e, reg_rdata);
   endtask

   task automatic done(input string t);
      $display("test %s finished, %0d mismatches so far", t, fails);
   endtask

   task automatic print_verdict;
      $display("compared %0d, mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      {reset, ce, clock_generator_pll, media_ready} = 4'hf;
      {reg_wr, reg_rd, rx_active, signal_detect, tx_en, tx_er} = 6'h0;
      {rec, spd, reg_addr, reg_wdata, txd} = 46'h0;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h08, 32'h1);
      rd(8'h18, 32'h0);
      wr(8'h04, 32'hffff_ffff);
      rd(8'h04, 32'h0);
      rd(8'h0c, 32'h0);
      // a write while ce is low must not land
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(8'h08, 32'h5);
      ce <= 1'b1;
      rd(8'h08, 32'h1);
      done("registers");
      // modes x {rx+tx, tx only, rx only with detect}
      for (int m = 0; m < 4; m++) begin
         wr(8'h00, {27'h0, MT[m]});
         for (int s = 0; s < 3; s++) begin
            @(posedge clk_sys);
            {rx_active, tx_en, signal_detect} <= {s != 1, s != 2, s == 2};
            repeat (8) @(negedge clk_sys);
            cmp("crs_col", {30'h0, EX[s][m]}, {30'h0, crs, col});
         end
      end
      @(posedge clk_sys);
      {rx_active, signal_detect} <= 2'b00;
      done("carrier");
      for (int k = 0; k < 4; k++) begin
         wr(8'h00, {27'h0, HM[k]});
         wr(8'h18, k < 3 ? 32'h80 : 32'h0);
         @(posedge clk_sys);
         tx_en <= 1'b1;
         @(posedge clk_sys);
         tx_en <= 1'b0;
         n = 0;
         repeat (40) begin
            @(negedge clk_sys);
            if (col === 1'b1)
               n++;
         end
         cmp("beat_len", HX[k], n);
      end
      done("heartbeat");
      // 100M with the medium stalled until the buffer refuses
      wr(8'h00, 32'h2);
      @(posedge clk_sys);
      {rec, spd, media_ready} <= 3'b110;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk_sys);
         {tx_en, tx_er, txd} <= {1'b1, i == 3, i[3:0]};
      end
      @(posedge clk_sys);
      tx_en <= 1'b0;
      @(negedge clk_sys);
      cmp("fifo_ready", 32'h0, {31'h0, tx_fifo_ready});
      // buffer words plus the one held in the symbol register
      cmp("accepted", DEPTH + 1, q.size());
      @(posedge clk_sys);
      media_ready <= 1'b1;
      repeat (30) @(posedge clk_sys);
      cmp("fifo_ready", 32'h1, {31'h0, tx_fifo_ready});
      wr(8'h00, 32'h0);
      spd <= 1'b0;
      @(posedge clk_sys);
      {tx_en, tx_er, txd} <= 6'h3a;
      @(posedge clk_sys);
      tx_en <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rec <= 1'b0;
      cmp("sym_count", q.size(), got.size());
      foreach (q[i])
         cmp("sym", {27'h0, q[i]}, {27'h0, got[i]});
      done("transmit");
      for (int k = 0; k < 3; k++) begin
         wr(8'h00, {27'h0, CM[k]});
         repeat (50) @(negedge clk_sys);
         {prev, n, seen} = {tx_clk, 32'h0, 32'h0};
         while (seen < 2) begin
            @(negedge clk_sys);
            if (seen == 1)
               n++;
            if (tx_clk && !prev)
               seen++;
            prev = tx_clk;
         end
         cmp("tx_clk_period", CP[k], n);
      end
      done("clocks");
      pms_sme_model_i.frame(1'b0, 5'h01, 5'h18, 16'h0080, 4, rv);
      rd(8'h18, 32'h80);
      pms_sme_model_i.frame(1'b1, 5'h01, 5'h18, 16'h0, 2, rv);
      cmp("mdio_hbctl", 32'h80, {16'h0, rv});
      pms_sme_model_i.frame(1'b1, 5'h01, 5'h02, 16'h0, 4, rv);
      cmp("mdio_phyad", 32'h1, {16'h0, rv});
      pms_sme_model_i.frame(1'b1, 5'h07, 5'h02, 16'h0, 2, rv);
      cmp("mdio_other", 32'hffff, {16'h0, rv});
      done("management");
      print_verdict();
   end
endmodule

bind pms_mii_core pms_mii_asserts pms_mii_asserts_i (.clk_sys, .reset, .ce,
   .reg_addr, .reg_wdata, .reg_wr, .mdio_out, .mdio_oe, .rx_active,
   .signal_detect, .crs, .col, .tx_en, .tx_sym_valid, .tx_sym_data,
   .tx_sym_halt);
`default_nettype wire
